// ==== rtl/dsa_regs.svh ====
`ifndef DSA_REGS_SVH
`define DSA_REGS_SVH

// data space map
`define DSA_IO_OFS 16'h0020
`define DSA_SRAM_LO 16'h0060
`define DSA_SRAM_HI 16'h025F
`define DSA_REG_TOP 16'h001F
// i/o space locations
`define DSA_STAT_IO 6'h3F
`define DSA_SP_LO_IO 6'h3D
`define DSA_SP_HI_IO 6'h3E
`define DSA_FLAG_IO 6'h1C
// status bits
`define DSA_BIT_I 7
`define DSA_BIT_T 6
// pointer pairs start at r26
`define DSA_PTR_BASE 5'h1A
// cycles per byte and wait-state extra
`define DSA_BYTE_CYC 3'h2
`define DSA_WAIT_CYC 3'h2
// reset values
`define DSA_STAT_RST 8'h00
`define DSA_SP_RST 16'h0000
`define DSA_FLAG_RST 8'h00

`endif

// ==== rtl/dsa_pkg.sv ====
`default_nettype none
package dsa_pkg;
    typedef enum logic [3:0] {
        OP_LD, OP_ST, OP_IN, OP_OUT, set_io_bit_op, clear_io_bit_op,
        skip_when_io_bit_high, skip_when_io_bit_low, store_bit_to_copy,
        load_bit_from_copy, OP_IRQ, return_from_irq
    } dsa_op_t;
    typedef enum logic [2:0] {
        AM_DIRECT, AM_IND, AM_DISP, AM_PREDEC, AM_POSTINC
    } dsa_mode_t;
    typedef struct packed {
        dsa_op_t op;
        dsa_mode_t mode;
        logic [1:0] ptr;
        logic [4:0] rd;
        logic [15:0] addr;
        logic [5:0] disp;
        logic [2:0] bitn;
    } dsa_req_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic oe;
        logic rd_n;
        logic wr_n;
    } dsa_xbus_t;
endpackage
`default_nettype wire

// ==== rtl/dsa_core.sv ====
// Contract
// - wait states add two cycles per byte; stack entry and return gain four.
// - direct, indirect, displacement, pre-decrement and post-increment addressing.
// - registers 26 to 31 hold the three pointers.
// - displacement adds up to 63 to the middle or top pointer.
// - pre-decrement lowers the pointer, post-increment raises it, during the access.
// - direct addressing reaches the full 16-bit data space.
// - registers, i/o, 512 internal and external bytes reachable in every mode.
// - register operand comes from the instruction register field.
// - i/o read and write move data between register and i/o 0..3F.
// - i/o seen from data space sits at i/o address plus 20.
// - bit set, clear and skip tests only on i/o 0..1F.
// - some flags clear on writing one; bit ops rewrite the whole register.
// - status register lives at i/o 3F, data address 5F.
// - global enable low blocks every interrupt.
// - taking an interrupt clears global enable; return sets it.
// - status bit 6 is the bit-copy holder for bit store and load.
// - interrupt entry takes four cycles, pushes two pc bytes, sp minus 2.
// - return takes four cycles, pops pc, sp plus 2, one instruction before next.
`include "dsa_regs.svh"
`default_nettype none
module dsa_core
    import dsa_pkg::*;
#(
    parameter int SRAM_BYTES = 512
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire dsa_req_t req,
    output logic req_ready,
    output logic done,
    output logic [7:0] rd_data,
    output logic skip,
    input wire logic rf_we,
    input wire logic [4:0] rf_waddr,
    input wire logic [7:0] rf_wdata,
    input wire logic [4:0] rf_raddr,
    output logic [7:0] rf_rdata,
    input wire logic ext_sram_en,
    input wire logic ext_wait_en,
    output var dsa_xbus_t xbus,
    input wire logic [7:0] xdata_in,
    input wire logic irq_pending,
    input wire logic [15:0] irq_vec,
    input wire logic [15:0] pc_cur,
    input wire logic instr_done,
    output logic pc_load,
    output logic [15:0] pc_load_val,
    input wire logic [7:0] flag_set,
    output logic [7:0] status_flags_reg,
    output logic [15:0] stack_ptr
);
    typedef enum logic {S_IDLE, S_BYTE} dsa_state_t;

    logic [7:0] rf_mem [0:31];
    logic [7:0] io_mem [0:63];
    logic [7:0] sram_mem [0:SRAM_BYTES-1];
    logic [7:0] stat_ff;
    logic [15:0] sp_ff;
    dsa_state_t st_ff;
    dsa_req_t op_ff;
    logic [15:0] addr_ff;
    logic [15:0] pc_ff;
    logic [15:0] pop_ff;
    logic [2:0] cnt_ff;
    logic byte_ff;
    logic hold_ff;
    logic done_ff;
    logic skip_ff;
    logic pcl_ff;
    logic [15:0] pcv_ff;
    logic [7:0] rdd_ff;

    // data space classification
    function automatic logic is_ext(input logic [15:0] a);
        is_ext = (a > `DSA_SRAM_HI);
    endfunction

    // cycles for one data byte, stretched on waited external access
    function automatic logic [2:0] cyc_of(input logic [15:0] a);
        cyc_of = `DSA_BYTE_CYC + ((ext_wait_en && ext_sram_en && is_ext(a)) ? `DSA_WAIT_CYC : 3'h0);
    endfunction

    // one byte read anywhere in the data space
    function automatic logic [7:0] ds_rd(input logic [15:0] a);
        logic [15:0] io_a;
        logic [15:0] sr_a;
        io_a = a - `DSA_IO_OFS;
        sr_a = a - `DSA_SRAM_LO;
        if (a <= `DSA_REG_TOP)
            ds_rd = rf_mem[a[4:0]];
        else if (a < `DSA_SRAM_LO) begin
            if (io_a[5:0] == `DSA_STAT_IO)
                ds_rd = stat_ff;
            else if (io_a[5:0] == `DSA_SP_LO_IO)
                ds_rd = sp_ff[7:0];
            else if (io_a[5:0] == `DSA_SP_HI_IO)
                ds_rd = sp_ff[15:8];
            else
                ds_rd = io_mem[io_a[5:0]];
        end else if (!is_ext(a))
            ds_rd = sram_mem[sr_a[8:0]];
        else
            ds_rd = ext_sram_en ? xdata_in : 8'h00;
    endfunction

    // pointer pair and effective address of a new request
    wire logic [4:0] ptr_lo = `DSA_PTR_BASE + {2'h0, req.ptr, 1'b0};
    wire logic [15:0] ptr_val = {rf_mem[ptr_lo + 5'h01], rf_mem[ptr_lo]};
    wire logic [15:0] ptr_dec = ptr_val - 16'h0001;
    wire logic [15:0] ptr_inc = ptr_val + 16'h0001;
    logic [15:0] ea;
    always_comb begin
        case (req.mode)
            AM_DIRECT: ea = req.addr;
            AM_IND: ea = ptr_val;
            AM_DISP: ea = ptr_val + {10'h000, req.disp};
            AM_PREDEC: ea = ptr_dec;
            AM_POSTINC: ea = ptr_val;
            default: ea = ptr_val;
        endcase
    end
    wire logic ptr_upd = (req.op == OP_LD || req.op == OP_ST) && (req.mode == AM_PREDEC || req.mode == AM_POSTINC);
    wire logic [15:0] ptr_new = (req.mode == AM_PREDEC) ? ptr_dec : ptr_inc;

    // start conditions; interrupts outrank requests
    wire logic idle = (st_ff == S_IDLE);
    wire logic irq_go = idle && irq_pending && stat_ff[`DSA_BIT_I] && !hold_ff;
    wire logic req_go = idle && !irq_go && req_valid;
    wire logic io_op = (req.op != OP_LD) && (req.op != OP_ST);
    wire logic bit_op = (req.op == set_io_bit_op) || (req.op == clear_io_bit_op)
        || (req.op == skip_when_io_bit_high) || (req.op == skip_when_io_bit_low);
    // bit ops see only the low 32 i/o locations
    wire logic [15:0] io_ea = `DSA_IO_OFS + {10'h000, bit_op ? {1'b0, req.addr[4:0]} : req.addr[5:0]};
    wire logic rmw_op = (req.op == set_io_bit_op) || (req.op == clear_io_bit_op);
    logic [2:0] req_cyc;
    always_comb begin
        req_cyc = io_op ? (rmw_op ? `DSA_BYTE_CYC : 3'h1) : cyc_of(ea);
    end

    // address, write data and write enable of the byte in flight
    wire logic is_irq = (op_ff.op == OP_IRQ);
    wire logic is_ret = (op_ff.op == return_from_irq);
    wire logic [15:0] sec_a = is_irq ? sp_ff - 16'h0001 : sp_ff + 16'h0002;
    wire logic [15:0] mem_a = is_irq ? (byte_ff ? sec_a : sp_ff)
        : is_ret ? (byte_ff ? sec_a : sp_ff + 16'h0001) : addr_ff;
    // the read function looks at storage, so a process keeps it fresh
    logic [7:0] mem_rd;
    always_comb begin
        mem_rd = ds_rd(mem_a);
    end
    wire logic [7:0] bit_mask = 8'h01 << op_ff.bitn;
    logic [7:0] mem_wd;
    logic mem_we;
    always_comb begin
        mem_we = 1'b1;
        case (op_ff.op)
            OP_ST, OP_OUT: mem_wd = rf_mem[op_ff.rd];
            set_io_bit_op: mem_wd = mem_rd | bit_mask;
            clear_io_bit_op: mem_wd = mem_rd & ~bit_mask;
            OP_IRQ: mem_wd = byte_ff ? pc_ff[15:8] : pc_ff[7:0];
            default: begin
                mem_wd = 8'h00;
                mem_we = 1'b0;
            end
        endcase
    end
    wire logic last = (st_ff == S_BYTE) && (cnt_ff == 3'h0);
    wire logic two_byte = is_irq || is_ret;
    wire logic fin = last && (!two_byte || byte_ff);
    wire logic wr = last && mem_we;
    wire logic [15:0] wr_io = mem_a - `DSA_IO_OFS;
    wire logic wr_rf = wr && (mem_a <= `DSA_REG_TOP);
    wire logic wr_iosp = wr && (mem_a > `DSA_REG_TOP) && (mem_a < `DSA_SRAM_LO);
    wire logic [15:0] sr_a = mem_a - `DSA_SRAM_LO;
    wire logic bit_val = mem_rd[op_ff.bitn];
    wire logic tbit = stat_ff[`DSA_BIT_T];

    // sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= S_IDLE;
            op_ff <= '0;
            addr_ff <= 16'h0000;
            pc_ff <= 16'h0000;
            cnt_ff <= 3'h0;
            byte_ff <= 1'b0;
        end else if (irq_go) begin
            st_ff <= S_BYTE;
            op_ff.op <= OP_IRQ;
            pc_ff <= pc_cur;
            cnt_ff <= cyc_of(sp_ff) - 3'h1;
            byte_ff <= 1'b0;
        end else if (req_go) begin
            st_ff <= S_BYTE;
            op_ff <= req;
            addr_ff <= io_op ? io_ea : ea;
            cnt_ff <= (req.op == return_from_irq) ? cyc_of(sp_ff + 16'h0001) - 3'h1 : req_cyc - 3'h1;
            byte_ff <= 1'b0;
        end else if (last && two_byte && !byte_ff) begin
            byte_ff <= 1'b1;
            cnt_ff <= cyc_of(sec_a) - 3'h1;
        end else if (fin) begin
            st_ff <= S_IDLE;
        end else if (st_ff == S_BYTE) begin
            cnt_ff <= cnt_ff - 3'h1;
        end
    end

    // working registers: user port, loads, stores and pointer updates
    always_ff @(posedge clk_sys) begin
        if (rf_we)
            rf_mem[rf_waddr] <= rf_wdata;
        if (req_go && ptr_upd) begin
            rf_mem[ptr_lo] <= ptr_new[7:0];
            rf_mem[ptr_lo + 5'h01] <= ptr_new[15:8];
        end
        if (wr_rf)
            rf_mem[mem_a[4:0]] <= mem_wd;
        if (last && (op_ff.op == OP_LD || op_ff.op == OP_IN))
            rf_mem[op_ff.rd] <= mem_rd;
        if (last && op_ff.op == load_bit_from_copy)
            rf_mem[op_ff.rd][op_ff.bitn] <= tbit;
    end

    // i/o and internal sram storage; hardware flag sets win over clears
    always_ff @(posedge clk_sys) begin
        if (rst)
            io_mem[`DSA_FLAG_IO] <= `DSA_FLAG_RST;
        else if (wr_iosp && wr_io[5:0] == `DSA_FLAG_IO)
            io_mem[`DSA_FLAG_IO] <= (io_mem[`DSA_FLAG_IO] & ~mem_wd) | flag_set;
        else
            io_mem[`DSA_FLAG_IO] <= io_mem[`DSA_FLAG_IO] | flag_set;
        if (wr_iosp && wr_io[5:0] != `DSA_FLAG_IO)
            io_mem[wr_io[5:0]] <= mem_wd;
        if (wr && mem_a >= `DSA_SRAM_LO && !is_ext(mem_a))
            sram_mem[sr_a[8:0]] <= mem_wd;
    end

    // status register and stack pointer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stat_ff <= `DSA_STAT_RST;
            sp_ff <= `DSA_SP_RST;
        end else begin
            if (wr_iosp && wr_io[5:0] == `DSA_STAT_IO)
                stat_ff <= mem_wd;
            else if (irq_go)
                stat_ff[`DSA_BIT_I] <= 1'b0;
            else if (fin && is_ret)
                stat_ff[`DSA_BIT_I] <= 1'b1;
            else if (last && op_ff.op == store_bit_to_copy)
                stat_ff[`DSA_BIT_T] <= rf_mem[op_ff.rd][op_ff.bitn];
            if (wr_iosp && wr_io[5:0] == `DSA_SP_LO_IO)
                sp_ff[7:0] <= mem_wd;
            else if (wr_iosp && wr_io[5:0] == `DSA_SP_HI_IO)
                sp_ff[15:8] <= mem_wd;
            else if (fin && is_irq)
                sp_ff <= sp_ff - 16'h0002;
            else if (fin && is_ret)
                sp_ff <= sp_ff + 16'h0002;
        end
    end

    // answers to the execution logic
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            done_ff <= 1'b0;
            skip_ff <= 1'b0;
            rdd_ff <= 8'h00;
            pcl_ff <= 1'b0;
            pcv_ff <= 16'h0000;
            pop_ff <= 16'h0000;
            hold_ff <= 1'b0;
        end else begin
            done_ff <= fin && !is_irq;
            pcl_ff <= fin && two_byte;
            // results move only with a done pulse, never on interrupt entry
            if (fin && !is_irq)
                rdd_ff <= mem_rd;
            if (fin && !is_irq)
                skip_ff <= (op_ff.op == skip_when_io_bit_high && bit_val)
                    || (op_ff.op == skip_when_io_bit_low && !bit_val);
            if (last && is_ret && !byte_ff)
                pop_ff[15:8] <= mem_rd;
            if (fin && is_irq)
                pcv_ff <= irq_vec;
            else if (fin && is_ret)
                pcv_ff <= {pop_ff[15:8], mem_rd};
            if (fin && is_ret)
                hold_ff <= 1'b1;
            else if (instr_done || (fin && !two_byte))
                hold_ff <= 1'b0;
        end
    end

    // external sram strobes follow the byte in flight
    wire logic x_act = (st_ff == S_BYTE) && ext_sram_en && is_ext(mem_a);
    assign xbus.addr = mem_a;
    assign xbus.wdata = mem_wd;
    assign xbus.oe = x_act && mem_we;
    assign xbus.rd_n = !(x_act && !mem_we);
    assign xbus.wr_n = !(x_act && mem_we);

    assign req_ready = idle && !irq_go;
    assign done = done_ff;
    assign skip = skip_ff;
    assign rd_data = rdd_ff;
    assign pc_load = pcl_ff;
    assign pc_load_val = pcv_ff;
    assign rf_rdata = rf_mem[rf_raddr];
    assign status_flags_reg = stat_ff;
    assign stack_ptr = sp_ff;
endmodule
`default_nettype wire

// ==== verif/dsa_xsram.sv ====
`default_nettype none
module dsa_xsram
    import dsa_pkg::*;
(
    input wire logic clk_sys,
    input wire dsa_xbus_t xbus,
    output logic [7:0] xdata_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    bit wrote [0:65535];
    logic [7:0] last = 8'h00;
    // store while write strobe low, track last driven byte
    always @(posedge clk_sys) begin
        if (!xbus.wr_n) begin
            mem[xbus.addr] <= xbus.wdata;
            wrote[xbus.addr] <= 1'b1;
        end
        if (!xbus.rd_n)
            last <= xdata_in;
    end
    // bus not driven outside a read: show inverse of last byte
    always_comb begin
        if (!xbus.rd_n && wrote[xbus.addr])
            xdata_in = mem[xbus.addr];
        else
            xdata_in = ~last;
    end
endmodule
`default_nettype wire

// ==== verif/dsa_core_chk.sv ====
`default_nettype none
module dsa_chk
    import dsa_pkg::*;
#(
    parameter int SRAM_BYTES = 512
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire dsa_req_t req,
    input wire logic req_ready,
    input wire logic done,
    input wire logic [7:0] rd_data,
    input wire logic skip,
    input wire logic ext_sram_en,
    input wire logic ext_wait_en,
    input wire logic irq_pending,
    input wire logic [15:0] irq_vec,
    input wire logic pc_load,
    input wire logic [15:0] pc_load_val,
    input wire logic [7:0] status_flags_reg,
    input wire logic [15:0] stack_ptr,
    input wire dsa_xbus_t xbus
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // request decode helpers
    wire logic take = req_valid && req_ready;
    wire logic ldst = (req.op == OP_LD || req.op == OP_ST) && req.mode == AM_DIRECT;
    wire logic [15:0] top_int = 16'h0060 + 16'(SRAM_BYTES) - 16'h0001;
    wire logic ext = req.addr > top_int && ext_sram_en && ext_wait_en;

    AST_RESET_IDLE: assert property ($fell(rst) |-> !done && req_ready && status_flags_reg == 8'h00
        && stack_ptr == 16'h0000) else $error("not idle after reset");
    AST_IO_TIME: assert property (take && (req.op == OP_IN || req.op == OP_OUT) |=> !req_ready ##1 done)
        else $error("io transfer timing wrong");
    AST_INT_TIME: assert property (take && ldst && !ext |=> !done [*2] ##1 done)
        else $error("internal access timing wrong");
    AST_EXT_WAIT: assert property (take && ldst && ext |=> !done [*4] ##1 done)
        else $error("wait state cycles wrong");
    AST_ENTRY: assert property ($fell(status_flags_reg[7]) && !done && !req_ready |-> ##4 pc_load
        && pc_load_val == irq_vec) else $error("interrupt entry wrong");
    AST_IRQ_BLOCK: assert property (!status_flags_reg[7] && irq_pending && req_ready && !req_valid |=> req_ready)
        else $error("interrupt taken while disabled");
    AST_RETURN: assert property (take && req.op == return_from_irq |-> ##[1:6] pc_load
        ##[0:2] status_flags_reg[7]) else $error("return did not finish");
    AST_DONE_PULSE: assert property (done |=> !done) else $error("done longer than one cycle");
    AST_XBUS_QUIET: assert property (req_ready |-> xbus.rd_n && xbus.wr_n && !xbus.oe)
        else $error("external strobe while idle");
    AST_RESULT_HELD: assert property (!done |-> $stable(rd_data) && $stable(skip))
        else $error("result changed without completion");

    CV_EXT: cover property (take && ldst && ext);
    CV_ENTRY: cover property (pc_load && !status_flags_reg[7]);
    CV_RET: cover property (take && req.op == return_from_irq);
endmodule
bind dsa_core dsa_chk #(.SRAM_BYTES(SRAM_BYTES)) u_chk (.*);
`default_nettype wire

// ==== verif/test_data_space_addressing_io_map.sv ====
`default_nettype none
module test_data_space_addressing_io_map
    import dsa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {dsa_req_t r; int lat; int k; logic [7:0] e;} dsa_row_t;
    logic clk_sys = 0, rst = 1, req_valid = 0, rf_we = 0, irq_pending = 0, instr_done = 0;
    logic ext_sram_en = 1, ext_wait_en = 1;
    logic req_ready, done, skip, pc_load;
    dsa_req_t req = '0;
    logic [4:0] rf_waddr = 5'h00, rf_raddr = 5'h00;
    logic [7:0] rf_wdata = 8'h00, flag_set = 8'h00, rd_data, rf_rdata, xdata_in, status_flags_reg;
    logic [15:0] pc_load_val, stack_ptr;
    dsa_xbus_t xbus;
    int err_total = 0;
    int compares = 0;
    dsa_row_t rows[$];
    logic [12:0] pre[12] = '{13'h0000, 13'h015A, 13'h02C3, 13'h0980, 13'h0A50, 13'h0B02,
        13'h1A00, 13'h1B01, 13'h1C80, 13'h1D01, 13'h1EF0, 13'h1F01};

    dsa_core #(.SRAM_BYTES(512)) dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .rd_data(rd_data), .skip(skip), .rf_we(rf_we),
        .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata),
        .ext_sram_en(ext_sram_en), .ext_wait_en(ext_wait_en), .xbus(xbus), .xdata_in(xdata_in),
        .irq_pending(irq_pending), .irq_vec(16'h0ABC), .pc_cur(16'h1234), .instr_done(instr_done),
        .pc_load(pc_load), .pc_load_val(pc_load_val), .flag_set(flag_set),
        .status_flags_reg(status_flags_reg), .stack_ptr(stack_ptr));
    dsa_xsram xmem (.clk_sys(clk_sys), .xbus(xbus), .xdata_in(xdata_in));

    // clock
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic give_verdict;
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic dsa_req_t mk(dsa_op_t o, dsa_mode_t m, int p, int d, int a, int b);
        return '{o, m, p[1:0], d[4:0], a[15:0], b[5:0], b[2:0]};
    endfunction

    // hold request until taken, count edges to done
    task automatic run(dsa_req_t r, output int n);
        req = r;
        req_valid = 1;
        n = 0;
        while (!req_ready && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        req_valid = 0;
        n = 1;
        while (!done && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    task automatic add(dsa_op_t o, dsa_mode_t m, int p, int d, int a, int b, int l, int k, logic [7:0] e);
        rows.push_back('{mk(o, m, p, d, a, b), l, k, e});
    endtask

    task automatic ldc(dsa_op_t o, int a, logic [7:0] e);
        int n;
        run(mk(o, AM_DIRECT, 0, 12, a, 0), n);
        chk("read", rd_data, e);
    endtask

    task automatic rfw(logic [4:0] a, logic [7:0] d);
        rf_we = 1;
        rf_waddr = a;
        rf_wdata = d;
        @(negedge clk_sys);
    endtask

    task automatic rdr(logic [4:0] a, logic [7:0] e);
        rf_raddr = a;
        @(negedge clk_sys);
        chk("reg", rf_rdata, e);
    endtask

    task automatic wpl;
        int n = 0;
        while (!pc_load && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    // main sequence
    initial begin
        int n;
        repeat (16) @(negedge clk_sys);
        rst = 0;
        chk("reset status", status_flags_reg, 8'h00);
        chk("reset sp", stack_ptr, 16'h0000);
        chk("reset ready", req_ready, 1'b1);
        foreach (pre[i])
            rfw(pre[i][12:8], pre[i][7:0]);
        rf_we = 0;
        add(OP_ST, AM_DIRECT, 0, 1, 16'h0100, 0, 3, 0, 8'h00);
        add(OP_LD, AM_DIRECT, 0, 3, 16'h0100, 0, 3, 1, 8'h5A);
        add(OP_LD, AM_IND, 0, 4, 0, 0, 3, 1, 8'h5A);
        add(OP_ST, AM_DISP, 1, 2, 0, 63, 3, 0, 8'h00);
        add(OP_LD, AM_DIRECT, 0, 5, 16'h01BF, 0, 3, 1, 8'hC3);
        add(OP_ST, AM_POSTINC, 2, 1, 0, 0, 3, 0, 8'h00);
        add(OP_LD, AM_PREDEC, 2, 6, 0, 0, 3, 1, 8'h5A);
        add(OP_OUT, AM_DIRECT, 0, 2, 16'h0010, 0, 2, 0, 8'h00);
        add(OP_LD, AM_DIRECT, 0, 7, 16'h0030, 0, 3, 1, 8'hC3);
        add(set_io_bit_op, AM_DIRECT, 0, 0, 16'h0010, 2, 3, 0, 8'h00);
        add(OP_IN, AM_DIRECT, 0, 3, 16'h0010, 0, 2, 1, 8'hC7);
        add(clear_io_bit_op, AM_DIRECT, 0, 0, 16'h0010, 7, 3, 0, 8'h00);
        add(OP_IN, AM_DIRECT, 0, 3, 16'h0010, 0, 2, 1, 8'h47);
        add(skip_when_io_bit_high, AM_DIRECT, 0, 0, 16'h0010, 6, 2, 2, 8'h01);
        add(skip_when_io_bit_low, AM_DIRECT, 0, 0, 16'h0010, 6, 2, 2, 8'h00);
        add(store_bit_to_copy, AM_DIRECT, 0, 1, 0, 1, 2, 3, 8'h01);
        add(load_bit_from_copy, AM_DIRECT, 0, 0, 0, 5, 2, 0, 8'h00);
        add(OP_ST, AM_DIRECT, 0, 1, 16'h8000, 0, 5, 0, 8'h00);
        add(OP_LD, AM_DIRECT, 0, 8, 16'h8000, 0, 5, 1, 8'h5A);
        foreach (rows[i]) begin
            run(rows[i].r, n);
            chk("cycles", 16'(n), 16'(rows[i].lat));
            if (rows[i].k != 0)
                chk("result", rows[i].k == 1 ? rd_data : rows[i].k == 2 ? skip : status_flags_reg[6],
                    rows[i].e);
        end
        // wait states off, then external memory absent
        ext_wait_en = 0;
        run(mk(OP_LD, AM_DIRECT, 0, 12, 16'h8000, 0), n);
        chk("cycles nowait", 16'(n), 16'h0003);
        chk("read nowait", rd_data, 8'h5A);
        ext_sram_en = 0;
        run(mk(OP_LD, AM_DIRECT, 0, 12, 16'h8000, 0), n);
        chk("cycles absent", 16'(n), 16'h0003);
        chk("read absent", rd_data, 8'h00);
        ext_sram_en = 1;
        ext_wait_en = 1;
        rdr(5'h00, 8'h20);
        rdr(5'h1E, 8'hF0);
        rdr(5'h1F, 8'h01);
        // flag raised by hardware, then a bit set elsewhere clears it
        flag_set = 8'h01;
        @(negedge clk_sys);
        flag_set = 8'h00;
        ldc(OP_IN, 16'h001C, 8'h01);
        run(mk(set_io_bit_op, AM_DIRECT, 0, 0, 16'h001C, 3), n);
        ldc(OP_IN, 16'h001C, 8'h00);
        // interrupt masked, then enabled, entered and returned
        irq_pending = 1;
        repeat (8) @(negedge clk_sys);
        chk("masked", req_ready, 1'b1);
        run(mk(OP_OUT, AM_DIRECT, 0, 10, 16'h003D, 0), n);
        run(mk(OP_OUT, AM_DIRECT, 0, 11, 16'h003E, 0), n);
        run(mk(OP_OUT, AM_DIRECT, 0, 9, 16'h003F, 0), n);
        wpl();
        chk("vector", pc_load_val, 16'h0ABC);
        chk("sp push", stack_ptr, 16'h024E);
        chk("i clear", status_flags_reg[7], 1'b0);
        irq_pending = 0;
        ldc(OP_LD, 16'h0250, 8'h34);
        ldc(OP_LD, 16'h024F, 8'h12);
        ldc(OP_IN, 16'h003F, 8'h00);
        run(mk(return_from_irq, AM_DIRECT, 0, 0, 0, 0), n);
        irq_pending = 1;
        chk("pc pop", pc_load_val, 16'h1234);
        chk("sp pop", stack_ptr, 16'h0250);
        chk("i set", status_flags_reg[7], 1'b1);
        repeat (6) @(negedge clk_sys);
        chk("hold", req_ready, 1'b1);
        instr_done = 1;
        @(negedge clk_sys);
        instr_done = 0;
        wpl();
        chk("entry", pc_load, 1'b1);
        give_verdict();
    end

    // watchdog
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_total++;
        give_verdict();
    end
endmodule
`default_nettype wire
